// ### design/bsc_cfg.svh
// register map, field layout and cycle counts of the branch/skip unit
`ifndef BSC_CFG_SVH
`define BSC_CFG_SVH
`define BSC_AW 8
`define BSC_A_OP 8'h00
`define BSC_A_OPND 8'h04
`define BSC_A_PTR 8'h08
`define BSC_A_PC 8'h0c
`define BSC_A_FLAG 8'h10
`define BSC_A_STAT 8'h14
`define BSC_HTRANS_ACT 1
`define BSC_HSIZE_WORD 3'h2
`define BSC_OP_LSB 0
`define BSC_OP_MSB 4
`define BSC_BIT_LSB 5
`define BSC_BIT_MSB 7
`define BSC_K_LSB 8
`define BSC_K_MSB 14
`define BSC_TWO_WORD 16
`define BSC_OPW_MSB 16
`define BSC_RD_LSB 0
`define BSC_RD_MSB 7
`define BSC_RR_LSB 8
`define BSC_RR_MSB 15
`define BSC_IO_LSB 16
`define BSC_IO_MSB 23
`define BSC_Z_MSB 15
`define BSC_F_C 0
`define BSC_F_Z 1
`define BSC_F_N 2
`define BSC_F_V 3
`define BSC_F_S 4
`define BSC_F_H 5
`define BSC_F_T 6
`define BSC_F_I 7
`define BSC_FLAG_RST 8'h00
`define BSC_CYC_ONE 3'h1
`define BSC_CYC_TWO 3'h2
`define BSC_CYC_THREE 3'h3
`define BSC_CYC_FOUR 3'h4
`define BSC_CYC_IND_CALL 3'h3
`define BSC_CYC_EXT_CALL 3'h3
`define BSC_STEP_NEXT 1
`define BSC_STEP_SKIP1 2
`define BSC_STEP_SKIP2 3
`endif

// ### design/bsc_pkg.sv
// shared types of the branch/skip control unit
package bsc_pkg;
  typedef enum logic [4:0] {
    OP_INDIRECT_CALL = 5'h00, OP_EXTENDED_INDIRECT_CALL = 5'h01,
    OP_COMPARE_REGS = 5'h02, OP_COMPARE_REGS_WITH_CARRY = 5'h03,
    OP_COMPARE_WITH_IMMEDIATE = 5'h04, OP_COMPARE_SKIP_EQUAL = 5'h05,
    OP_SKIP_REG_BIT_CLEAR = 5'h06, OP_SKIP_REG_BIT_SET = 5'h07,
    OP_SKIP_IO_BIT_CLEAR = 5'h08, OP_SKIP_IO_BIT_SET = 5'h09,
    OP_BRANCH_STATUS_BIT_SET = 5'h0a, OP_BRANCH_STATUS_BIT_CLEAR = 5'h0b,
    OP_BRANCH_EQUAL = 5'h0c, OP_BRANCH_NOT_EQUAL = 5'h0d,
    OP_BRANCH_CARRY_SET = 5'h0e, OP_BRANCH_CARRY_CLEAR = 5'h0f,
    OP_BRANCH_SAME_OR_HIGHER = 5'h10, OP_BRANCH_LOWER = 5'h11,
    OP_BRANCH_MINUS = 5'h12, OP_BRANCH_PLUS = 5'h13,
    OP_BRANCH_SIGNED_GE = 5'h14, OP_BRANCH_SIGNED_LT = 5'h15,
    OP_BRANCH_HALF_CARRY_SET = 5'h16, OP_BRANCH_HALF_CARRY_CLEAR = 5'h17,
    OP_BRANCH_TRANSFER_FLAG_SET = 5'h18, OP_BRANCH_TRANSFER_FLAG_CLEAR = 5'h19,
    OP_BRANCH_OVERFLOW_SET = 5'h1a, OP_BRANCH_OVERFLOW_CLEAR = 5'h1b,
    OP_BRANCH_IRQ_ENABLED = 5'h1c, OP_BRANCH_IRQ_DISABLED = 5'h1d
  } bsc_op_t;
  typedef enum logic [1:0] {
    BSC_S_IDLE = 2'h1,
    BSC_S_EXEC = 2'h2
  } bsc_state_t;
endpackage

// ### design/bsc_cmp_alu.sv
// compare subtractor: flags of rd - rr - carry, result discarded
`timescale 1ns/10ps
`default_nettype none
`include "bsc_cfg.svh"
module bsc_cmp_alu (
  input  wire logic [7:0] i_rd,
  input  wire logic [7:0] i_rr,
  input  wire logic       i_use_carry,
  input  wire logic [7:0] i_status,
  output logic      [7:0] o_status
);
  logic [7:0] res;
  logic       cin;
  assign cin = i_use_carry & i_status[`BSC_F_C];
  assign res = i_rd - i_rr - {7'h00, cin};
  always_comb begin
    o_status = i_status;
    o_status[`BSC_F_H] = (~i_rd[3] & i_rr[3]) | (i_rr[3] & res[3]) | (res[3] & ~i_rd[3]);
    o_status[`BSC_F_V] = (i_rd[7] & ~i_rr[7] & ~res[7]) | (~i_rd[7] & i_rr[7] & res[7]);
    o_status[`BSC_F_N] = res[7];
    o_status[`BSC_F_S] = res[7] ^ o_status[`BSC_F_V];
    o_status[`BSC_F_C] = (~i_rd[7] & i_rr[7]) | (i_rr[7] & res[7]) | (res[7] & ~i_rd[7]);
    // with carry, zero can only survive a zero from the lower byte
    o_status[`BSC_F_Z] = (res == 8'h00) & (~i_use_carry | i_status[`BSC_F_Z]);
  end
endmodule // bsc_cmp_alu
`default_nettype wire

// ### design/bsc_cond_eval.sv
// classifies an operation and evaluates its skip or branch condition
`timescale 1ns/10ps
`default_nettype none
`include "bsc_cfg.svh"
module bsc_cond_eval
  import bsc_pkg::*;
(
  input  wire bsc_op_t    i_op,
  input  wire logic [2:0] i_bit_sel,
  input  wire logic [7:0] i_status,
  input  wire logic [7:0] i_rd,
  input  wire logic [7:0] i_rr,
  input  wire logic [7:0] i_io,
  output logic            o_branch,
  output logic            o_skip,
  output logic            o_io,
  output logic            o_cond
);
  logic nxv;
  assign nxv = i_status[`BSC_F_N] ^ i_status[`BSC_F_V];
  assign o_branch = (i_op >= OP_BRANCH_STATUS_BIT_SET) && (i_op <= OP_BRANCH_IRQ_DISABLED);
  assign o_skip = (i_op >= OP_COMPARE_SKIP_EQUAL) && (i_op <= OP_SKIP_IO_BIT_SET);
  assign o_io = (i_op == OP_SKIP_IO_BIT_CLEAR) || (i_op == OP_SKIP_IO_BIT_SET);
  always_comb begin
    unique case (i_op)
      OP_COMPARE_SKIP_EQUAL:         o_cond = (i_rd == i_rr);
      OP_SKIP_REG_BIT_CLEAR:         o_cond = ~i_rd[i_bit_sel];
      OP_SKIP_REG_BIT_SET:           o_cond = i_rd[i_bit_sel];
      OP_SKIP_IO_BIT_CLEAR:          o_cond = ~i_io[i_bit_sel];
      OP_SKIP_IO_BIT_SET:            o_cond = i_io[i_bit_sel];
      OP_BRANCH_STATUS_BIT_SET:      o_cond = i_status[i_bit_sel];
      OP_BRANCH_STATUS_BIT_CLEAR:    o_cond = ~i_status[i_bit_sel];
      OP_BRANCH_EQUAL:               o_cond = i_status[`BSC_F_Z];
      OP_BRANCH_NOT_EQUAL:           o_cond = ~i_status[`BSC_F_Z];
      OP_BRANCH_MINUS:               o_cond = i_status[`BSC_F_N];
      OP_BRANCH_PLUS:                o_cond = ~i_status[`BSC_F_N];
      OP_BRANCH_CARRY_SET,
      OP_BRANCH_LOWER:               o_cond = i_status[`BSC_F_C];
      OP_BRANCH_CARRY_CLEAR,
      OP_BRANCH_SAME_OR_HIGHER:      o_cond = ~i_status[`BSC_F_C];
      OP_BRANCH_SIGNED_GE:           o_cond = ~nxv;
      OP_BRANCH_SIGNED_LT:           o_cond = nxv;
      OP_BRANCH_HALF_CARRY_SET:      o_cond = i_status[`BSC_F_H];
      OP_BRANCH_HALF_CARRY_CLEAR:    o_cond = ~i_status[`BSC_F_H];
      OP_BRANCH_TRANSFER_FLAG_SET:   o_cond = i_status[`BSC_F_T];
      OP_BRANCH_TRANSFER_FLAG_CLEAR: o_cond = ~i_status[`BSC_F_T];
      OP_BRANCH_OVERFLOW_SET:        o_cond = i_status[`BSC_F_V];
      OP_BRANCH_OVERFLOW_CLEAR:      o_cond = ~i_status[`BSC_F_V];
      OP_BRANCH_IRQ_ENABLED:         o_cond = i_status[`BSC_F_I];
      OP_BRANCH_IRQ_DISABLED:        o_cond = ~i_status[`BSC_F_I];
      default:                       o_cond = 1'b0;
    endcase
  end
endmodule // bsc_cond_eval
`default_nettype wire

// ### design/bsc_branch_skip_ctrl.sv
// branch/skip control unit with its AHB-Lite register slave
//
// The address map and the AHB-Lite interface to the registers were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
`include "bsc_cfg.svh"
// Overview of operation
// - indirect call: counter low 16 bits from pointer, upper bits zero, three cycles
// - extended indirect call: low and upper counter bits both from pointer register, three cycles
// - compare-skip-equal skips next instruction when both registers match, no flags
// - compares subtract without storing, update Z C N V S H in one cycle
// - register-bit skips skip when selected bit is clear or set, one to three
// - io-bit skips skip on selected io bit, two to four cycles
// - status branches jump to counter plus offset plus one on chosen bit
// - carry-set and lower on carry one; carry-clear and same-or-higher on zero
// - signed greater-or-equal on N xor V zero; less-than on one
// - half-carry branches follow the half-carry flag
// - transfer-flag branches follow the transfer flag
// - overflow branches follow the overflow flag
// - interrupt-state branches follow the global interrupt enable flag
module bsc_branch_skip_ctrl
  import bsc_pkg::*;
#(
  parameter int PC_W = 22
) (
  input  wire logic            i_clk_sys,
  input  wire logic            i_rst,
  input  wire logic            i_hsel,
  input  wire logic [31:0]     i_haddr,
  input  wire logic [1:0]      i_htrans,
  input  wire logic            i_hwrite,
  input  wire logic [2:0]      i_hsize,
  input  wire logic [31:0]     i_hwdata,
  input  wire logic            i_hready,
  output logic                 o_hreadyout,
  output logic [31:0]          o_hrdata,
  output logic                 o_hresp,
  output logic [PC_W-1:0]      o_pc,
  output logic [7:0]           o_status,
  output logic                 o_busy
);
  localparam int AW = `BSC_AW;
  localparam int K_W = `BSC_K_MSB - `BSC_K_LSB + 1;
  localparam logic [PC_W-1:0] STEP_NEXT = PC_W'(`BSC_STEP_NEXT);
  localparam logic [PC_W-1:0] STEP_SKIP1 = PC_W'(`BSC_STEP_SKIP1);
  localparam logic [PC_W-1:0] STEP_SKIP2 = PC_W'(`BSC_STEP_SKIP2);

  // the counter must hold the 16-bit pointer plus an extension byte part
  if (PC_W < 17 || PC_W > 22) begin : g_pc_w_check
    $error("PC_W must lie between 17 and 22");
  end

  //////////////////////////////////////////////////////////////////////////////
  logic                 hready_reg;
  logic [31:0]          hrdata_reg;
  logic                 hresp_reg;
  logic                 dp_wr_reg;
  logic [AW-1:0]        dp_addr_reg;
  logic [`BSC_OPW_MSB:0] op_word_reg;
  logic [`BSC_IO_MSB:0] opnd_reg;
  logic [PC_W-1:0]      ptr_reg;
  logic [PC_W-1:0]      pc_reg;
  logic [7:0]           status_reg;
  bsc_state_t           state_reg;
  logic                 busy_reg;
  logic [2:0]           cnt_reg;
  logic [PC_W-1:0]      tgt_reg;
  logic [7:0]           flags_reg;
  logic                 upd_reg;
  logic                 taken_reg;
  logic [2:0]           last_cyc_reg;

  logic                 ap_take;
  logic                 ap_hit;
  logic                 wr_ok;
  logic                 wr_op;
  logic                 commit_w;
  logic [31:0]          rd_mux;
  bsc_op_t              op_in;
  logic [2:0]           bit_in;
  logic [K_W-1:0]       k_in;
  logic                 two_in;
  logic [PC_W-1:0]      k_ext;
  logic [7:0]           rd_w;
  logic [7:0]           rr_w;
  logic [7:0]           io_w;
  logic                 br_w;
  logic                 skip_w;
  logic                 iosk_w;
  logic                 cond_w;
  logic                 cmp_w;
  logic [7:0]           alu_status;
  logic [PC_W-1:0]      tgt_next;
  logic [2:0]           cyc_next;
  logic                 upd_next;
  logic                 taken_next;

  //////////////////////////////////////////////////////////////////////////////
  // bus slave: zero wait states, every answer OKAY
  assign ap_take = i_hsel & i_htrans[`BSC_HTRANS_ACT] & i_hready;
  // unmapped, unaligned or narrow accesses read zero and drop writes
  assign ap_hit = (i_haddr[31:AW] == '0) && (i_haddr[1:0] == 2'h0)
               && (i_haddr[AW-1:0] <= `BSC_A_STAT) && (i_hsize == `BSC_HSIZE_WORD);

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      dp_wr_reg <= 1'b0;
      dp_addr_reg <= '0;
    end else begin
      dp_wr_reg <= ap_take & i_hwrite & ap_hit;
      dp_addr_reg <= i_haddr[AW-1:0];
    end
  end

  always_comb begin
    unique case (i_haddr[AW-1:0])
      `BSC_A_OP:   rd_mux = {15'h0000, op_word_reg};
      `BSC_A_OPND: rd_mux = {8'h00, opnd_reg};
      `BSC_A_PTR:  rd_mux = 32'(ptr_reg);
      `BSC_A_PC:   rd_mux = 32'(pc_reg);
      `BSC_A_FLAG: rd_mux = {24'h000000, status_reg};
      `BSC_A_STAT: rd_mux = {21'h000000, last_cyc_reg, 6'h00, taken_reg, busy_reg};
      default:     rd_mux = 32'h00000000;
    endcase
  end

  // read data is captured at the address phase, so it shows the state then
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      hrdata_reg <= 32'h00000000;
      hready_reg <= 1'b1;
      hresp_reg <= 1'b0;
    end else begin
      hrdata_reg <= (ap_take & ~i_hwrite & ap_hit) ? rd_mux : 32'h00000000;
      hready_reg <= 1'b1;
      hresp_reg <= 1'b0;
    end
  end

  // writes arriving while an instruction executes are dropped
  assign wr_ok = dp_wr_reg & ~busy_reg;
  assign wr_op = wr_ok & (dp_addr_reg == `BSC_A_OP);

  //////////////////////////////////////////////////////////////////////////////
  // decode of the issued instruction word
  assign op_in = bsc_op_t'(i_hwdata[`BSC_OP_MSB:`BSC_OP_LSB]);
  assign bit_in = i_hwdata[`BSC_BIT_MSB:`BSC_BIT_LSB];
  assign k_in = i_hwdata[`BSC_K_MSB:`BSC_K_LSB];
  assign two_in = i_hwdata[`BSC_TWO_WORD];
  assign k_ext = {{(PC_W-K_W){k_in[K_W-1]}}, k_in};
  assign rd_w = opnd_reg[`BSC_RD_MSB:`BSC_RD_LSB];
  assign rr_w = opnd_reg[`BSC_RR_MSB:`BSC_RR_LSB];
  assign io_w = opnd_reg[`BSC_IO_MSB:`BSC_IO_LSB];
  assign cmp_w = (op_in == OP_COMPARE_REGS) || (op_in == OP_COMPARE_REGS_WITH_CARRY)
              || (op_in == OP_COMPARE_WITH_IMMEDIATE);

  bsc_cond_eval u_cond (
    .i_op      (op_in),
    .i_bit_sel (bit_in),
    .i_status  (status_reg),
    .i_rd      (rd_w),
    .i_rr      (rr_w),
    .i_io      (io_w),
    .o_branch  (br_w),
    .o_skip    (skip_w),
    .o_io      (iosk_w),
    .o_cond    (cond_w)
  );

  // immediate compares take the constant from the second operand byte
  bsc_cmp_alu u_alu (
    .i_rd        (rd_w),
    .i_rr        (rr_w),
    .i_use_carry (op_in == OP_COMPARE_REGS_WITH_CARRY),
    .i_status    (status_reg),
    .o_status    (alu_status)
  );

  always_comb begin
    tgt_next = pc_reg + STEP_NEXT;
    cyc_next = `BSC_CYC_ONE;
    upd_next = 1'b0;
    taken_next = 1'b0;
    if (op_in == OP_INDIRECT_CALL) begin
      tgt_next = {{(PC_W-16){1'b0}}, ptr_reg[`BSC_Z_MSB:0]};
      cyc_next = `BSC_CYC_IND_CALL;
      taken_next = 1'b1;
    end else if (op_in == OP_EXTENDED_INDIRECT_CALL) begin
      tgt_next = ptr_reg;
      cyc_next = `BSC_CYC_EXT_CALL;
      taken_next = 1'b1;
    end else if (cmp_w) begin
      upd_next = 1'b1;
    end else if (skip_w) begin
      cyc_next = iosk_w ? `BSC_CYC_TWO : `BSC_CYC_ONE;
      if (cond_w) begin
        taken_next = 1'b1;
        tgt_next = pc_reg + (two_in ? STEP_SKIP2 : STEP_SKIP1);
        if (iosk_w && two_in) begin
          cyc_next = `BSC_CYC_FOUR;
        end else if (iosk_w || two_in) begin
          cyc_next = `BSC_CYC_THREE;
        end else begin
          cyc_next = `BSC_CYC_TWO;
        end
      end
    end else if (br_w && cond_w) begin
      taken_next = 1'b1;
      tgt_next = pc_reg + STEP_NEXT + k_ext;
      cyc_next = `BSC_CYC_TWO;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // operand registers, refused while busy
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      opnd_reg <= '0;
      ptr_reg <= '0;
      op_word_reg <= '0;
    end else begin
      if (wr_ok && dp_addr_reg == `BSC_A_OPND) begin
        opnd_reg <= i_hwdata[`BSC_IO_MSB:0];
      end
      if (wr_ok && dp_addr_reg == `BSC_A_PTR) begin
        ptr_reg <= i_hwdata[PC_W-1:0];
      end
      if (wr_op) begin
        op_word_reg <= i_hwdata[`BSC_OPW_MSB:0];
      end
    end
  end

  // sequencer: holds the decision for the documented number of cycles
  assign commit_w = (state_reg == BSC_S_EXEC) && (cnt_reg == `BSC_CYC_ONE);

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      state_reg <= BSC_S_IDLE;
      busy_reg <= 1'b0;
      cnt_reg <= 3'h0;
      tgt_reg <= '0;
      flags_reg <= `BSC_FLAG_RST;
      upd_reg <= 1'b0;
      taken_reg <= 1'b0;
      last_cyc_reg <= 3'h0;
    end else begin
      unique case (state_reg)
        BSC_S_IDLE: begin
          if (wr_op) begin
            state_reg <= BSC_S_EXEC;
            busy_reg <= 1'b1;
            cnt_reg <= cyc_next;
            tgt_reg <= tgt_next;
            flags_reg <= alu_status;
            upd_reg <= upd_next;
            taken_reg <= taken_next;
            last_cyc_reg <= cyc_next;
          end
        end
        BSC_S_EXEC: begin
          if (commit_w) begin
            state_reg <= BSC_S_IDLE;
            busy_reg <= 1'b0;
          end else begin
            cnt_reg <= cnt_reg - `BSC_CYC_ONE;
          end
        end
        default: begin
          state_reg <= BSC_S_IDLE;
          busy_reg <= 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      pc_reg <= '0;
    end else if (commit_w) begin
      pc_reg <= tgt_reg;
    end else if (wr_ok && dp_addr_reg == `BSC_A_PC) begin
      pc_reg <= i_hwdata[PC_W-1:0];
    end
  end

  // skips and branches leave the flags alone
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      status_reg <= `BSC_FLAG_RST;
    end else if (commit_w && upd_reg) begin
      status_reg <= flags_reg;
    end else if (wr_ok && dp_addr_reg == `BSC_A_FLAG) begin
      status_reg <= i_hwdata[7:0];
    end
  end

  assign o_hreadyout = hready_reg;
  assign o_hrdata = hrdata_reg;
  assign o_hresp = hresp_reg;
  assign o_pc = pc_reg;
  assign o_status = status_reg;
  assign o_busy = busy_reg;

  //////////////////////////////////////////////////////////////////////////////
  a_ind_call_target: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    wr_op && op_in == OP_INDIRECT_CALL |=> busy_reg [*3] ##1
      (!busy_reg && pc_reg[PC_W-1:16] == '0 && pc_reg[15:0] == $past(ptr_reg[15:0], 4)))
    else $error("indirect call target or length wrong");

  a_ext_call_target: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    wr_op && op_in == OP_EXTENDED_INDIRECT_CALL |=> busy_reg [*3] ##1
      (!busy_reg && pc_reg == $past(ptr_reg, 4)))
    else $error("extended indirect call target or length wrong");

  a_cmp_skip_eq: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    wr_op && op_in == OP_COMPARE_SKIP_EQUAL && rd_w == rr_w && !two_in |=>
      busy_reg [*2] ##1 (!busy_reg && pc_reg == $past(pc_reg, 3) + STEP_SKIP1
      && status_reg == $past(status_reg, 3)))
    else $error("compare-skip did not skip one word in two cycles");

  a_cmp_zero_flag: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    wr_op && op_in == OP_COMPARE_REGS |=> busy_reg ##1 (!busy_reg
      && status_reg[`BSC_F_Z] == ($past(rd_w, 2) == $past(rr_w, 2))
      && status_reg[`BSC_F_C] == ($past(rd_w, 2) < $past(rr_w, 2))))
    else $error("compare flags wrong or not one cycle");

  a_regbit_skip2: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    wr_op && op_in == OP_SKIP_REG_BIT_SET && rd_w[bit_in] && two_in |=>
      busy_reg [*3] ##1 (!busy_reg && pc_reg == $past(pc_reg, 4) + STEP_SKIP2))
    else $error("register bit skip over two words wrong");

  a_iobit_noskip: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    wr_op && iosk_w && !cond_w |=> busy_reg [*2] ##1
      (!busy_reg && pc_reg == $past(pc_reg, 3) + STEP_NEXT))
    else $error("io bit test without skip not two cycles");

  a_branch_taken: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    wr_op && op_in == OP_BRANCH_STATUS_BIT_SET && status_reg[bit_in] |=> busy_reg [*2]
      ##1 (!busy_reg && pc_reg == $past(pc_reg, 3) + STEP_NEXT + $past(k_ext, 3)))
    else $error("status branch taken to wrong target");

  a_ne_flags_kept: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    wr_op && op_in == OP_BRANCH_NOT_EQUAL && !status_reg[`BSC_F_Z] |=>
      $stable(status_reg) && busy_reg ##1 $stable(status_reg) && busy_reg ##1 !busy_reg)
    else $error("not-equal branch changed flags or length");

  a_signed_ge: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    wr_op && op_in == OP_BRANCH_SIGNED_GE && !(status_reg[`BSC_F_N] ^ status_reg[`BSC_F_V])
      |=> busy_reg [*2] ##1 !busy_reg)
    else $error("signed greater-or-equal branch not taken");

  a_branch_not_taken: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    wr_op && br_w && !cond_w |=> busy_reg ##1
      (!busy_reg && pc_reg == $past(pc_reg, 2) + STEP_NEXT))
    else $error("untaken branch not one cycle to next word");
endmodule // bsc_branch_skip_ctrl
`default_nettype wire

// ### test/bsc_prog_mem.sv
// program memory model: tells whether the word at the counter starts a long instruction
`timescale 1ns/10ps
`default_nettype none
module bsc_prog_mem #(
  parameter int PC_W = 22
) (
  input  wire logic [PC_W-1:0] i_pc,
  output logic                 o_two_word
);
  // fixed scatter of two-word instructions, so skips land on both widths
  assign o_two_word = i_pc[1] ^ i_pc[4];
endmodule // bsc_prog_mem
`default_nettype wire

// ### test/branch_skip_control_unit_test.sv
// self-checking bench of the branch/skip control unit
`timescale 1ns/10ps
`default_nettype none
`include "bsc_cfg.svh"
`define CHK(nm, ex, gt) begin cmp_count++; if ((ex) !== (gt)) begin n_mismatch++; \
  $display("wrong value %s expected %h seen %h", nm, ex, gt); end end
module branch_skip_control_unit_test
  import bsc_pkg::*;
;
  logic        clk, rst, hsel, hwrite, hready, hresp, busy, two_word;
  logic [31:0] haddr, hwdata, hrdata, rdat, seed;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [21:0] pc;
  logic [7:0]  status;
  int          n_mismatch = 0;
  int          cmp_count = 0;

  bsc_branch_skip_ctrl #(.PC_W(22)) dut (.i_clk_sys(clk), .i_rst(rst), .i_hsel(hsel),
    .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(hsize),
    .i_hwdata(hwdata), .i_hready(hready), .o_hreadyout(hready), .o_hrdata(hrdata),
    .o_hresp(hresp), .o_pc(pc), .o_status(status), .o_busy(busy));
  bsc_prog_mem #(.PC_W(22)) u_mem (.i_pc(pc), .o_two_word(two_word));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge clk);
    hsel <= 1'b1; htrans <= 2'h2; haddr <= {24'h0, a}; hwrite <= wr; hsize <= 3'h2;
    do @(posedge clk); while (hready !== 1'b1);
    hsel <= 1'b0; htrans <= 2'h0; hwdata <= wd;
    do @(posedge clk); while (hready !== 1'b1);
    rdat = hrdata;
    `CHK("hresp", 1'b0, hresp)
  endtask

  function automatic void expect_of(input logic [31:0] w, opnd, ptr, input logic [21:0] p,
      input logic [7:0] s, output logic [21:0] np, output logic [7:0] ns,
      output logic [2:0] n, output logic hit);
    logic [4:0] op; logic [2:0] b; logic [8:0] r, tbl; logic [7:0] rd, rr; logic [3:0] idx;
    op = w[4:0]; b = w[7:5]; rd = opnd[7:0]; rr = opnd[15:8];
    np = p + 22'h1; ns = s; n = 3'h1; hit = 1'b0;
    tbl = {s[7], s[3], s[6], s[5], s[2] ^ s[3], s[2], s[0], s[0], s[1]};
    if (op <= 5'h01) begin
      hit = 1'b1; n = 3'h3; np = {(op == 5'h01) ? ptr[21:16] : 6'h0, ptr[15:0]};
    end else if (op <= 5'h04) begin
      r = {1'b0, rd} - {1'b0, rr} - ((op == 5'h03) ? {8'h0, s[0]} : 9'h0);
      ns[0] = r[8]; ns[1] = (r[7:0] == 8'h0) & ((op != 5'h03) | s[1]); ns[2] = r[7];
      ns[3] = (rd[7] & ~rr[7] & ~r[7]) | (~rd[7] & rr[7] & r[7]); ns[4] = ns[2] ^ ns[3];
      ns[5] = (~rd[3] & rr[3]) | (rr[3] & r[3]) | (r[3] & ~rd[3]);
    end else if (op <= 5'h09) begin
      hit = (op == 5'h05) ? (rd == rr) : (op <= 5'h07) ? (rd[b] == op[0]) : (opnd[16+b] == op[0]);
      n = {2'b0, op >= 5'h08} + (hit ? 3'h2 + {2'b0, w[16]} : 3'h1);
      if (hit) np = p + 22'h2 + {21'h0, w[16]};
    end else if (op <= 5'h1d) begin
      idx = (op >= 5'h0c) ? 4'((op - 5'h0c) >> 1) : 4'hf;
      hit = ((idx == 4'hf) ? s[b] : tbl[idx]) ^ op[0] ^ (idx == 4'h2 || idx == 4'h4);
      if (hit) begin
        n = 3'h2; np = p + 22'h1 + {{15{w[14]}}, w[14:8]};
      end
    end
  endfunction

  // poke writes the counter while the instruction runs; the write must be dropped
  task automatic run_one(input logic [31:0] w, opnd, ptr, input logic [21:0] p,
      input logic [7:0] s, input logic poke);
    logic [21:0] ep; logic [7:0] es; logic [2:0] en; logic eh; int cnt;
    ahb(1'b1, `BSC_A_PC, {10'h0, p});
    ahb(1'b1, `BSC_A_FLAG, {24'h0, s});
    ahb(1'b1, `BSC_A_OPND, opnd);
    ahb(1'b1, `BSC_A_PTR, ptr);
    w[16] = two_word;
    expect_of(w, opnd, ptr, p, s, ep, es, en, eh);
    ahb(1'b1, `BSC_A_OP, w);
    if (poke) ahb(1'b1, `BSC_A_PC, {10'h0, ~p});
    #1;
    // the poke transfer spends three edges of the run
    cnt = poke ? 3 : 0;
    while (busy === 1'b1 && cnt < 16) begin
      @(posedge clk); #1; cnt++;
    end
    `CHK("cycles", {1'b0, en}, 4'(cnt))
    `CHK("pc", ep, pc)
    `CHK("flags", es, status)
    ahb(1'b0, `BSC_A_STAT, 32'h0);
    `CHK("stat", {en, eh}, {rdat[10:8], rdat[1]})
    ahb(1'b0, `BSC_A_OPND, 32'h0);
    `CHK("opnd", opnd[23:0], rdat[23:0])
  endtask

  task automatic give_verdict();
    if (n_mismatch == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (60000) @(posedge clk);
    n_mismatch++;
    give_verdict();
  end

  initial begin
    logic [31:0] w, opnd;
    rst = 1'b1; hsel = 1'b0; htrans = 2'h0; haddr = 32'h0; hwrite = 1'b0;
    hsize = 3'h2; hwdata = 32'h0; seed = 32'hd786;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    run_one({17'h0, 7'h7f, 3'h0, OP_EXTENDED_INDIRECT_CALL}, 0, 32'h2abcde, 22'h5, 8'h0, 1);
    run_one({17'h0, 7'h40, 3'h0, OP_BRANCH_STATUS_BIT_SET}, 0, 0, 22'h0, 8'h01, 0);
    run_one({17'h0, 7'h3f, 3'h0, OP_BRANCH_NOT_EQUAL}, 0, 0, 22'h3fffff, 8'hfd, 0);
    run_one({27'h0, OP_COMPARE_REGS_WITH_CARRY}, 32'h5555, 0, 22'h7, 8'h03, 0);
    ahb(1'b0, 8'h18, 32'h0);
    `CHK("unmapped", 32'h0, rdat)
    ahb(1'b0, 8'h05, 32'h0);
    `CHK("unaligned", 32'h0, rdat)
    for (int i = 0; i < 300; i++) begin
      seed = lfsr(seed); w = {17'h0, seed[14:0]};
      seed = lfsr(lfsr(seed)); opnd = {8'h0, seed[23:0]};
      if ((w[4:0] == 5'h05 && seed[30]) || w[4:0] == 5'h06 || w[4:0] == 5'h07)
        opnd[15:8] = opnd[7:0];
      run_one(w, opnd, lfsr(seed), seed[29:8] ^ 22'h155, seed[31:24], 0);
    end
    give_verdict();
  end
endmodule // branch_skip_control_unit_test
`default_nettype wire
